// ===== rtl/sbsc_pkg.sv
// sbsc_pkg: shared constants for the synchronous burst sram control block
// assumes: one 100 MHz clock, synchronous active-low reset
`default_nettype none
package sbsc_pkg;
  localparam int unsigned CLK_PERIOD_NS       = 10;
  localparam int unsigned ADDR_W              = 20;
  localparam int unsigned DATA_W              = 36;
  localparam int unsigned NUM_BYTES           = 4;
  localparam int unsigned BURST_W             = 2;
  localparam int unsigned SLEEP_ENTRY_CYCLES  = 2;
  localparam int unsigned SLEEP_WAKE_CYCLES   = 2;
  localparam int unsigned SLEEP_CNT_W         = 2;
  localparam logic [1:0]  BURST_ZERO          = 2'h0;
  localparam logic [1:0]  BURST_ONE           = 2'h1;
  localparam logic [1:0]  SLEEP_CNT_ZERO      = 2'h0;
  localparam logic [1:0]  SLEEP_CNT_ONE       = 2'h1;

  typedef enum logic [3:0] {
    SBSC_CMD_DESEL = 4'h1,
    SBSC_CMD_READ  = 4'h2,
    SBSC_CMD_WRITE = 4'h4,
    SBSC_CMD_ABORT = 4'h8
  } sbsc_cmd_t;

  typedef enum logic [3:0] {
    SBSC_PWR_ACTIVE = 4'h1,
    SBSC_PWR_ENTER  = 4'h2,
    SBSC_PWR_SLEEP  = 4'h4,
    SBSC_PWR_WAKE   = 4'h8
  } sbsc_pwr_t;
endpackage : sbsc_pkg
`default_nettype wire

// ===== rtl/sbsc_burst_addr.sv
// sbsc_burst_addr: burst address generator, load or advance
// assumes: load and advance come from the same clock; never both high
`default_nettype none
module sbsc_burst_addr
  import sbsc_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
)
(
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          nrst_i,
  // control
  input  wire logic          load_i,
  input  wire logic          advance_i,
  input  wire logic          burst_order_select_n_i,
  input  wire logic [AW-1:0] ext_addr_i,
  // result
  output logic      [AW-1:0] burst_addr_o
);
  logic [AW-1:0]      base_r;
  logic [BURST_W-1:0] count_r;
  logic [BURST_W-1:0] count_nxt;
  logic [BURST_W-1:0] low_bits;
  logic [BURST_W-1:0] count_use;

  assign count_nxt = load_i ? BURST_ZERO : (count_r + BURST_ONE);
  // a continue shows its advanced address in the cycle it is taken
  assign count_use = advance_i ? count_nxt : count_r;
  // linear adds the count, interleaved xors it
  assign low_bits  = burst_order_select_n_i ? (base_r[BURST_W-1:0] ^ count_use)
                                            : (base_r[BURST_W-1:0] + count_use);
  assign burst_addr_o = {base_r[AW-1:BURST_W], low_bits};

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      base_r  <= '0;
      count_r <= BURST_ZERO;
    end
    else if (load_i || advance_i)
    begin
      if (load_i)
        base_r <= ext_addr_i;
      count_r <= count_nxt;
    end
  end
endmodule : sbsc_burst_addr
`default_nettype wire

// ===== rtl/sbsc_top.sv
// sbsc_top: command decode, burst sequencing, data pipeline, sleep control
// assumes: enable and sleep pins pass through its two-flop synchronisers; memory array outside
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - all selects, load, write high: read begins
// - advance high continues burst, ignores selects
// - read with output enable high is dummy
// - selected load, write low, byte strobe: write
// - write with no byte strobe is no-op
// - any select inactive on load deselects
// - continue after deselect stays deselected
// - clock gate high holds burst, address and pipeline state; sleep and enable keep running
// - drivers off during writes regardless enable, except a read just before a write drives in its data cycle
// - enable and sleep asynchronous, others sampled
// - outputs high impedance from power-up
// - two-bit counter, wraps after four accesses
// - linear order increments low two bits
// - interleaved order xors count into start
// - flow-through low, else pipeline default
// - sleep after two cycles, wake two
// - asleep: deselected, inputs ignored, bus off
// - sleep pin pulled low by default
// - pipeline read data after second edge
// - flow-through read data one cycle earlier
module sbsc_top
  import sbsc_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned DW = DATA_W,
  parameter int unsigned NB = NUM_BYTES
)
(
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          nrst_i,
  // command pins
  input  wire logic          clock_gate_n_i,
  input  wire logic          advance_load_i,
  input  wire logic          write_strobe_n_i,
  input  wire logic [NB-1:0] byte_write_strobe_n_i,
  input  wire logic          chip_select_one_n_i,
  input  wire logic          chip_select_two_i,
  input  wire logic          chip_select_three_n_i,
  input  wire logic [AW-1:0] addr_i,
  // mode and asynchronous pins
  input  wire logic          output_enable_n_i,
  input  wire logic          sleep_request_i,
  input  wire logic          burst_order_select_n_i,
  input  wire logic          flow_through_select_n_i,
  // data pins, three-signal form
  input  wire logic [DW-1:0] dq_i,
  output logic      [DW-1:0] dq_o,
  output logic               dq_oe_n_o,
  // memory array side
  output logic      [AW-1:0] mem_addr_o,
  output logic               mem_rd_o,
  input  wire logic [DW-1:0] mem_rdata_i,
  output logic               mem_wr_o,
  output logic      [AW-1:0] mem_waddr_o,
  output logic      [NB-1:0] mem_wbe_o,
  output logic      [DW-1:0] mem_wdata_o,
  // status
  output logic               asleep_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first flop feeds only the second
  logic s1_oe_n_r;
  logic s2_oe_n_r;
  logic s1_zz_r;
  logic s2_zz_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      s1_oe_n_r <= 1'b1;
      s2_oe_n_r <= 1'b1;
      s1_zz_r   <= 1'b0;
      s2_zz_r   <= 1'b0;
    end
    else
    begin
      s1_oe_n_r <= output_enable_n_i;
      s2_oe_n_r <= s1_oe_n_r;
      s1_zz_r   <= sleep_request_i;
      s2_zz_r   <= s1_zz_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep sequencing
  sbsc_pwr_t              pwr_r;
  sbsc_pwr_t              pwr_nxt;
  logic [SLEEP_CNT_W-1:0] scnt_r;
  logic [SLEEP_CNT_W-1:0] scnt_nxt;
  wire  sleep_done = (scnt_r == SLEEP_CNT_ONE);
  wire  pwr_sleep  = (pwr_r == SBSC_PWR_SLEEP);

  always_comb
  begin
    pwr_nxt  = pwr_r;
    scnt_nxt = (scnt_r == SLEEP_CNT_ZERO) ? SLEEP_CNT_ZERO : scnt_r - SLEEP_CNT_ONE;
    unique case (pwr_r)
      SBSC_PWR_ACTIVE:
        if (s2_zz_r)
        begin
          pwr_nxt  = SBSC_PWR_ENTER;
          scnt_nxt = SLEEP_CNT_W'(SLEEP_ENTRY_CYCLES);
        end
      SBSC_PWR_ENTER:
        if (sleep_done)
          pwr_nxt = SBSC_PWR_SLEEP;
      SBSC_PWR_SLEEP:
        if (!s2_zz_r)
        begin
          pwr_nxt  = SBSC_PWR_WAKE;
          scnt_nxt = SLEEP_CNT_W'(SLEEP_WAKE_CYCLES);
        end
      SBSC_PWR_WAKE:
        if (s2_zz_r)
          pwr_nxt = SBSC_PWR_SLEEP;
        else if (sleep_done)
          pwr_nxt = SBSC_PWR_ACTIVE;
      default:
        pwr_nxt = SBSC_PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      pwr_r  <= SBSC_PWR_ACTIVE;
      scnt_r <= SLEEP_CNT_ZERO;
    end
    else
    begin
      pwr_r  <= pwr_nxt;
      scnt_r <= scnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  // recovery still runs the pipeline; writes then are the controller's fault
  wire edge_en   = !clock_gate_n_i && !pwr_sleep;
  wire selected  = !chip_select_one_n_i && chip_select_two_i && !chip_select_three_n_i;
  wire any_byte  = |(~byte_write_strobe_n_i);
  wire is_load   = edge_en && !advance_load_i;
  wire is_adv    = edge_en && advance_load_i;

  sbsc_cmd_t burst_r;      // kind of burst in progress
  sbsc_cmd_t cmd_now;      // effective command this edge

  always_comb
  begin
    cmd_now = SBSC_CMD_DESEL;
    if (is_load)
    begin
      if (!selected)
        cmd_now = SBSC_CMD_DESEL;
      else if (write_strobe_n_i)
        cmd_now = SBSC_CMD_READ;
      else if (any_byte)
        cmd_now = SBSC_CMD_WRITE;
      else
        cmd_now = SBSC_CMD_ABORT;
    end
    else if (is_adv)
    begin
      // selects and write strobe ignored on continue
      if (burst_r == SBSC_CMD_DESEL)
        cmd_now = SBSC_CMD_DESEL;
      else if (burst_r == SBSC_CMD_READ)
        cmd_now = SBSC_CMD_READ;
      else if (any_byte)
        cmd_now = SBSC_CMD_WRITE;
      else
        cmd_now = SBSC_CMD_ABORT;
    end
  end

  wire do_read  = (cmd_now == SBSC_CMD_READ);
  wire do_write = (cmd_now == SBSC_CMD_WRITE);
  // a load that is an abort still carries the write burst kind
  wire load_wr  = is_load && selected && !write_strobe_n_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      burst_r <= SBSC_CMD_DESEL;
    else if (is_load)
      burst_r <= !selected ? SBSC_CMD_DESEL : (load_wr ? SBSC_CMD_WRITE : SBSC_CMD_READ);
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst address
  wire [AW-1:0] cur_addr;
  sbsc_burst_addr #(
    .AW (AW)
  ) u_addr (
    .ref_clk_i              (ref_clk_i),
    .nrst_i                 (nrst_i),
    .load_i                 (is_load && selected),
    .advance_i              (is_adv),
    .burst_order_select_n_i (burst_order_select_n_i),
    .ext_addr_i             (addr_i),
    .burst_addr_o           (cur_addr)
  );
  // the address module already shows the advanced address on a continue
  wire [BURST_W-1:0] nxt_low = cur_addr[BURST_W-1:0];
  wire pipe_mode = flow_through_select_n_i;

  ////////////////////////////////////////////////////////////////////////////
  // read pipeline: stage one access, stage two output register
  logic          rd1_r;
  logic          rd2_r;
  logic [DW-1:0] rq_r;
  logic [AW-1:0] maddr_r;
  logic          mrd_r;

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      rd1_r   <= 1'b0;
      rd2_r   <= 1'b0;
      rq_r    <= '0;
      maddr_r <= '0;
      mrd_r   <= 1'b0;
    end
    else if (edge_en)
    begin
      maddr_r <= is_load ? addr_i : {cur_addr[AW-1:BURST_W], nxt_low};
      mrd_r   <= do_read;
      rd1_r   <= do_read;
      rd2_r   <= rd1_r;
      rq_r    <= mem_rdata_i;
    end
    else if (pwr_sleep)
    begin
      rd1_r <= 1'b0;
      rd2_r <= 1'b0;
      mrd_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write pipeline: command stage, then the data-due stage of pipeline mode
  // stages survive sleep, so a write left in flight lands after wake-up
  logic          wr1_r;
  logic          wr2_r;
  logic [AW-1:0] wa1_r;
  logic [AW-1:0] wa2_r;
  logic [NB-1:0] wb1_r;
  logic [NB-1:0] wb2_r;

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      wr1_r <= 1'b0;
      wr2_r <= 1'b0;
      wa1_r <= '0;
      wa2_r <= '0;
      wb1_r <= '0;
      wb2_r <= '0;
    end
    else if (edge_en)
    begin
      wr1_r <= do_write;
      wa1_r <= is_load ? addr_i : cur_addr;
      wb1_r <= ~byte_write_strobe_n_i;
      wr2_r <= wr1_r;
      wa2_r <= wa1_r;
      wb2_r <= wb1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write commit and bus drive
  logic          mwr_r;
  logic [AW-1:0] mwa_r;
  logic [NB-1:0] mwbe_r;
  logic [DW-1:0] mwd_r;
  logic [DW-1:0] dq_r;
  logic          oe_n_r;
  wire           wr_due  = pipe_mode ? wr2_r : wr1_r;
  wire [AW-1:0]  wa_due  = pipe_mode ? wa2_r : wa1_r;
  wire [NB-1:0]  wb_due  = pipe_mode ? wb2_r : wb1_r;
  wire           rd_due  = pipe_mode ? rd2_r : rd1_r;
  wire [DW-1:0]  rd_data = pipe_mode ? rq_r : mem_rdata_i;
  wire           drive   = rd_due && !s2_oe_n_r && !wr_due && !pwr_sleep;

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      mwr_r  <= 1'b0;
      mwa_r  <= '0;
      mwbe_r <= '0;
      mwd_r  <= '0;
      dq_r   <= '0;
      oe_n_r <= 1'b1;
    end
    else
    begin
      mwr_r  <= edge_en && wr_due;
      mwa_r  <= wa_due;
      mwbe_r <= wb_due;
      mwd_r  <= dq_i;
      dq_r   <= rd_data;
      oe_n_r <= !drive;
    end
  end

  assign dq_o        = dq_r;
  assign dq_oe_n_o   = oe_n_r;
  assign mem_addr_o  = maddr_r;
  assign mem_rd_o    = mrd_r;
  assign mem_wr_o    = mwr_r;
  assign mem_waddr_o = mwa_r;
  assign mem_wbe_o   = mwbe_r;
  assign mem_wdata_o = mwd_r;

  logic asleep_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      asleep_r <= 1'b0;
    else
      asleep_r <= pwr_sleep;
  end
  assign asleep_o = asleep_r;
endmodule : sbsc_top
`default_nettype wire

// ===== sim/sbsc_chk_sva.sv
// sbsc_chk: port-level assertions for the burst sram control block
// assumes: bound to sbsc_top, one clock, synchronous active-low reset
`default_nettype none
module sbsc_chk
  import sbsc_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned NB = NUM_BYTES
)
(
  // command and mode pins
  input wire logic          ref_clk_i, nrst_i, clock_gate_n_i, advance_load_i, write_strobe_n_i,
  input wire logic          chip_select_one_n_i, chip_select_two_i, chip_select_three_n_i,
  input wire logic          output_enable_n_i, sleep_request_i, flow_through_select_n_i,
  // outputs watched
  input wire logic [NB-1:0] byte_write_strobe_n_i, mem_wbe_o,
  input wire logic          dq_oe_n_o, mem_wr_o, mem_rd_o, asleep_o,
  input wire logic [AW-1:0] mem_addr_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // sleep pins are excluded so the synchroniser lag cannot make a false antecedent
  wire logic ok  = !clock_gate_n_i && !sleep_request_i && !asleep_o;
  wire logic sel = !chip_select_one_n_i && chip_select_two_i && !chip_select_three_n_i;
  wire logic ld  = ok && !advance_load_i && sel;
  wire logic rd  = ld && write_strobe_n_i;
  wire logic wr  = ld && !write_strobe_n_i && byte_write_strobe_n_i != '1;
  ////////////////////////////////////////
  sequence s_rd;
    !output_enable_n_i[*4] ##0 rd;
  endsequence
  property p_rst;
    disable iff (1'b0) !nrst_i |=> dq_oe_n_o && !mem_wr_o && !asleep_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_slp_off;
    asleep_o |-> dq_oe_n_o && !mem_wr_o;
  endproperty
  a_slp_off: assert property (p_slp_off) else $error("activity while asleep");
  property p_slp_in;
    sleep_request_i[*7] |-> asleep_o;
  endproperty
  a_slp_in: assert property (p_slp_in) else $error("sleep not entered");
  property p_slp_out;
    !sleep_request_i[*7] |-> !asleep_o;
  endproperty
  a_slp_out: assert property (p_slp_out) else $error("sleep not left");
  property p_hold;
    clock_gate_n_i && !sleep_request_i |=> $stable(mem_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved on gated edge");
  property p_rd_pipe;
    s_rd ##0 flow_through_select_n_i ##1 (ok && !output_enable_n_i)[*2] |=> !dq_oe_n_o;
  endproperty
  a_rd_pipe: assert property (p_rd_pipe) else $error("pipeline read not driven");
  property p_rd_flow;
    s_rd ##0 !flow_through_select_n_i ##1 (ok && !output_enable_n_i) |=> !dq_oe_n_o;
  endproperty
  a_rd_flow: assert property (p_rd_flow) else $error("flow read not driven");
  property p_wr_pipe;
    wr && flow_through_select_n_i ##1 ok[*2] |=> mem_wr_o;
  endproperty
  a_wr_pipe: assert property (p_wr_pipe) else $error("pipeline write missing");
  property p_wr_flow;
    wr && !flow_through_select_n_i ##1 ok |=> mem_wr_o;
  endproperty
  a_wr_flow: assert property (p_wr_flow) else $error("flow write missing");
  property p_rd_strobe;
    rd |=> mem_rd_o;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("array read strobe missing");
  property p_abort;
    mem_wr_o |-> mem_wbe_o != '0;
  endproperty
  a_abort: assert property (p_abort) else $error("write without byte lane");
  property p_desel;
    (ok && !advance_load_i && !sel)[*3] |=> dq_oe_n_o;
  endproperty
  a_desel: assert property (p_desel) else $error("bus driven while deselected");
  c_rd: cover property (rd ##2 !dq_oe_n_o);
  c_wr: cover property (mem_wr_o);
  c_slp: cover property (asleep_o);
endmodule : sbsc_chk
`default_nettype wire

// ===== sim/sbsc_mem_model.sv
// sbsc_mem_model: behavioural storage array behind the block
// assumes: read data settles in the cycle the read address is shown
`default_nettype none
module sbsc_mem_model
  import sbsc_pkg::*;
(
  input  wire logic                 ref_clk_i, mem_wr_o,
  input  wire logic [ADDR_W-1:0]    mem_addr_o, mem_waddr_o,
  input  wire logic [NUM_BYTES-1:0] mem_wbe_o,
  input  wire logic [DATA_W-1:0]    mem_wdata_o,
  output var  logic [DATA_W-1:0]    mem_rdata_i
);
  localparam int BW = DATA_W / NUM_BYTES;
  logic [DATA_W-1:0] m [logic [ADDR_W-1:0]];
  // unwritten words read as an address pattern so stale data cannot pass
  always @(mem_addr_o, negedge ref_clk_i)
    mem_rdata_i = m.exists(mem_addr_o) ? m[mem_addr_o] : ~DATA_W'(mem_addr_o);
  always @(posedge ref_clk_i)
    if (mem_wr_o)
      for (int b = 0; b < NUM_BYTES; b++)
        if (mem_wbe_o[b]) m[mem_waddr_o][b*BW +: BW] = mem_wdata_o[b*BW +: BW];
endmodule : sbsc_mem_model
`default_nettype wire

// ===== sim/sync_burst_sram_control_tb_top.sv
// sync_burst_sram_control_tb_top: directed bench, bench acts as controller
// assumes: storage model behind the block, checker bound below
`default_nettype none
module sync_burst_sram_control_tb_top
  import sbsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [ADDR_W-1:0] BASE = 20'h5a3c4;
  logic ref_clk_i = 0, nrst_i = 0, clock_gate_n_i = 1, advance_load_i = 0, write_strobe_n_i = 1;
  logic chip_select_one_n_i = 1, chip_select_two_i = 0, chip_select_three_n_i = 1;
  logic output_enable_n_i = 0, sleep_request_i = 0, burst_order_select_n_i = 0, flow_through_select_n_i = 1;
  logic [NUM_BYTES-1:0] byte_write_strobe_n_i = '1, mem_wbe_o;
  logic [ADDR_W-1:0] addr_i = '0, mem_addr_o, mem_waddr_o;
  logic [DATA_W-1:0] dq_i = '0, dq_o, mem_rdata_i, mem_wdata_o, dp0 = '0, dp1 = '0, junk, d[4];
  logic dq_oe_n_o, mem_rd_o, mem_wr_o, asleep_o;
  logic [DATA_W-1:0] rq[$];
  int errors = 0, num_checks = 0, cyc_n = 0;
  sbsc_top dut_u (.*);
  sbsc_mem_model mem_u (.*);
  always #5 ref_clk_i = ~ref_clk_i;
  // idle data lines change every cycle so a missed capture cannot match
  assign junk = ~DATA_W'(cyc_n);
  always @(posedge ref_clk_i)
    if (nrst_i && dq_oe_n_o === 1'b0) rq.push_back(dq_o);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input logic advance_load, wn, input logic [3:0] bw, input logic [2:0] cs,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    clock_gate_n_i <= 1'b0;
    advance_load_i <= advance_load;
    write_strobe_n_i <= wn;
    byte_write_strobe_n_i <= bw;
    {chip_select_one_n_i, chip_select_two_i, chip_select_three_n_i} <= cs;
    addr_i <= a;
    dq_i <= flow_through_select_n_i ? dp1 : dp0;
    dp1 = dp0;
    dp0 = wd;
    @(posedge ref_clk_i);
  endtask : cyc
  task automatic idl(input int n);
    repeat (n) cyc(1'b0, 1'b1, 4'hf, 3'h5, BASE, junk);
  endtask : idl
  function automatic logic [1:0] ba(input logic il, input logic [1:0] s, input int k);
    return il ? s ^ 2'(k) : s + 2'(k);
  endfunction : ba
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  always @(posedge ref_clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000)
    begin
      errors++;
      test_done();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    logic [1:0] r, j;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    chk("reset outputs", {dq_oe_n_o, mem_wr_o, asleep_o}, 3'h4);
    for (int m = 0; m < 2; m++)
    begin
      flow_through_select_n_i <= m[0];
      burst_order_select_n_i <= m[0];
      idl(4);
      for (int k = 0; k < 4; k++)
      begin
        d[k] = {m[3:0], k[7:0], 24'ha5c3e1};
        cyc(k != 0, 1'b0, 4'h0, ON, BASE | 2, d[k]);
        if (k == 2)
        begin
          clock_gate_n_i <= 1'b1;
          @(posedge ref_clk_i);
        end
      end
      burst_order_select_n_i <= !m[0];
      idl(4);
      for (int k = 0; k < 5; k++) cyc(k != 0, 1'b1, 4'hf, ON, BASE | 1, junk);
      idl(4);
      chk("beat count", rq.size(), 5);
      for (int k = 0; k < 5; k++)
      begin
        r = ba(!m[0], 2'h1, k);
        j = m[0] ? r ^ 2'h2 : r - 2'h2;
        chk("read data", rq.pop_front(), d[j]);
      end
    end
    cyc(1'b0, 1'b0, 4'hf, ON, BASE, junk);
    idl(4);
    cyc(1'b0, 1'b1, 4'hf, ON, BASE, junk);
    foreach (d[c])
    begin
      cyc(1'b0, 1'b1, 4'hf, 3'(c == 0 ? 6 : c == 1 ? 0 : c == 2 ? 3 : 5), BASE, junk);
      cyc(1'b1, 1'b1, 4'hf, ON, BASE, junk);
    end
    output_enable_n_i <= 1'b1;
    idl(4);
    cyc(1'b0, 1'b1, 4'hf, ON, BASE, junk);
    idl(4);
    output_enable_n_i <= 1'b0;
    idl(4);
    chk("read count", rq.size(), 1);
    chk("abort kept data", rq.pop_front(), d[2]);
    sleep_request_i <= 1'b1;
    idl(8);
    chk("asleep", asleep_o, 1'b1);
    cyc(1'b0, 1'b0, 4'h0, ON, BASE, junk);
    idl(4);
    sleep_request_i <= 1'b0;
    idl(8);
    chk("awake", asleep_o, 1'b0);
    cyc(1'b0, 1'b1, 4'hf, ON, BASE, junk);
    idl(4);
    chk("sleep read count", rq.size(), 1);
    chk("sleep kept data", rq.pop_front(), d[2]);
    test_done();
  end
endmodule : sync_burst_sram_control_tb_top
bind sbsc_top sbsc_chk #(.AW(AW), .NB(NB)) chk_u (.*);
`default_nettype wire
